// File: i2c_page_pkg.sv
// shared constants for the i2c memory page port and its master
package i2c_page_pkg;
  localparam logic [6:0] PAGE_TEST = 7'h20;  // test registers
  localparam logic [6:0] PAGE_RAM = 7'h21;  // internal_ram_page
  localparam logic [6:0] PAGE_EFR = 7'h22;  // extended_function_registers
  localparam logic [6:0] PAGE_PHI = 7'h23;  // program memory high address
  localparam logic [6:0] PAGE_PLO = 7'h24;  // program memory low address
  localparam logic [6:0] PAGE_ECACHE = 7'h25;  // eeprom cache
  localparam logic [6:0] PAGE_RSVD = 7'h26;  // reserved, acked only as a write address after a register byte
  localparam int PHI_BITS = 5;  // high program address bits
  localparam int PADDR_BITS = 13;  // full program address
  localparam int SCL_DIV = 40;  // pclk cycles per scl half period
  // control register offsets of the master's apb slave
  localparam logic [11:0] OFS_CTRL = 12'h000;  // [0] go, [1] read
  localparam logic [11:0] OFS_ADDR = 12'h004;  // [6:0] page, [15:8] reg addr
  localparam logic [11:0] OFS_WDATA = 12'h008;  // [7:0] write data
  localparam logic [11:0] OFS_STATUS = 12'h00c;  // [0] busy, [1] nack, [15:8] rdata
endpackage : i2c_page_pkg

// File: i2c_link_if.sv
// i2c wire pair joining master and slave ends
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl_o, scl_oe;  // master drives scl
  logic sda_m_o, sda_m_oe;  // master sda drive
  logic sda_s_o, sda_s_oe;  // slave sda drive
  logic scl, sda;  // resolved wire levels, pulled up
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
  modport slave (output sda_s_o, sda_s_oe, input scl, sda);
endinterface : i2c_link_if
`default_nettype wire

// File: pin_sync.sv
// two-stage synchroniser with edge and level outputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic lvl,
  output logic rise,
  output logic fall
);
  logic s1_r;  // first stage, read only by the second
  logic s2_r;  // settled level
  logic s3_r;  // previous settled level for edges
  // pull-up idle is one, so reset to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign lvl = s2_r;
  assign rise = s2_r && !s3_r;
  assign fall = !s2_r && s3_r;
endmodule : pin_sync
`default_nettype wire

// File: i2c_page_slave.sv
// i2c slave end: paged byte access to internal memories
`timescale 1ns/1ps
`default_nettype none
module i2c_page_slave (
  input wire logic pclk,
  input wire logic presetn,
  i2c_link_if.slave link,
  input wire logic mem_grant,
  output logic mem_we,
  output logic mem_re,
  output logic [2:0] mem_page,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic [i2c_page_pkg::PADDR_BITS-1:0] prog_addr
);
  import i2c_page_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_AACK = 3'b011, S_REG = 3'b010,
    S_RACK = 3'b110, S_DATA = 3'b111, S_DACK = 3'b101, S_SEND = 3'b100
  } slv_e;
  slv_e st_r;  // protocol state
  logic scl, scl_rise, scl_fall, sda, sda_rise, sda_fall;
  logic [7:0] sh_r;  // receive/transmit shift register
  logic [2:0] cnt_r;  // bit counter
  logic [2:0] page_r;  // selected page index
  logic [7:0] reg_r;  // register address
  logic have_reg_r;  // a register address was taken this frame
  logic ack_r;  // driving ack low
  logic tx_r;  // transmitting read data
  logic mack_r;  // master acked our byte
  logic full_r;  // eight bits taken since the last ack slot or start
  logic [PHI_BITS-1:0] phi_r;  // held high program address
  logic start_c, stop_c;
  logic ok_c;  // address matches a reachable page
  pin_sync u_scl (.pclk(pclk), .presetn(presetn), .pin(link.scl), .lvl(scl),
    .rise(scl_rise), .fall(scl_fall));
  pin_sync u_sda (.pclk(pclk), .presetn(presetn), .pin(link.sda), .lvl(sda),
    .rise(sda_rise), .fall(sda_fall));
  // start and stop are sda edges with scl high
  assign start_c = sda_fall && scl;
  assign stop_c = sda_rise && scl;
  // page decode; only test page without grant, reserved never
  function automatic logic page_ok(input logic [6:0] a, input logic g);
    page_ok = (a == PAGE_TEST) ||
      (g && (a >= PAGE_RAM) && (a <= PAGE_ECACHE));
  endfunction : page_ok
  assign ok_c = page_ok(sh_r[7:1], mem_grant);
  // main protocol sequencer; we never touch scl
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      page_r <= 3'h0;
      reg_r <= 8'h00;
      have_reg_r <= 1'b0;
      ack_r <= 1'b0;
      tx_r <= 1'b0;
      mack_r <= 1'b0;
      full_r <= 1'b0;
    end else if (stop_c) begin
      st_r <= S_IDLE;  // stop ends any read
      ack_r <= 1'b0;
      tx_r <= 1'b0;
      have_reg_r <= 1'b0;
    end else if (start_c) begin
      st_r <= S_ADDR;  // a repeated start keeps the register address
      cnt_r <= 3'h0;
      full_r <= 1'b0;
      ack_r <= 1'b0;
      tx_r <= 1'b0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          st_r <= S_IDLE;
        end
        S_ADDR, S_REG, S_DATA: begin
          // sample on scl rising, sda high reads as one
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda};
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) full_r <= 1'b1;
          end
          // the counter alone is zero at the first fall too, so a byte must be full
          if (scl_fall && cnt_r == 3'h0 && full_r) begin
            // eighth bit done: move to ack slot
            full_r <= 1'b0;
            if (st_r == S_ADDR) begin
              // first write address page bits ignored later
              ack_r <= ok_c || (!sh_r[0] && have_reg_r);
              if (ok_c) page_r <= sh_r[3:1];
              st_r <= (ok_c || (!sh_r[0] && have_reg_r)) ? S_AACK : S_IDLE;
            end else begin
              ack_r <= 1'b1;  // receiver acks by pulling low
              st_r <= (st_r == S_REG) ? S_RACK : S_DACK;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            ack_r <= 1'b0;
            if (sh_r[0]) begin
              // read: load one byte of the second-address page
              st_r <= S_SEND;
              tx_r <= 1'b1;
              sh_r <= mem_rdata;
              cnt_r <= 3'h0;
            end else begin
              st_r <= S_REG;  // register address follows
              cnt_r <= 3'h0;
            end
          end
        end
        S_RACK: begin
          if (scl_fall) begin
            ack_r <= 1'b0;
            reg_r <= sh_r;
            have_reg_r <= 1'b1;
            st_r <= S_DATA;  // data byte is second of two
            cnt_r <= 3'h0;
          end
        end
        S_DACK: begin
          if (scl_fall) begin
            ack_r <= 1'b0;
            st_r <= S_IDLE;  // one byte per write frame
          end
        end
        S_SEND: begin
          // shift out msb first, changing after scl falls
          if (scl_rise) begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) mack_r <= 1'b0;
          end
          if (scl_fall && tx_r) begin
            sh_r <= {sh_r[6:0], 1'b1};
            if (cnt_r == 3'h0) tx_r <= 1'b0;  // release for master ack slot
          end
          if (scl_rise && !tx_r) begin
            mack_r <= !sda;
            st_r <= S_IDLE;  // single byte per read; master stops
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
  // sda drive: ack low or data zero, open drain
  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = ack_r || (tx_r && !sh_r[7]);
  // memory write strobe after data ack completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_we <= (st_r == S_DACK) && scl_fall && !start_c && !stop_c &&
        (page_r != PAGE_PHI[2:0]);
      if (st_r == S_DACK && scl_fall) mem_wdata <= sh_r;
    end
  end
  // read fetch strobe when the read address is acked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mem_re <= 1'b0;
    else mem_re <= (st_r == S_ADDR) && scl_fall && cnt_r == 3'h0 && full_r && ok_c && sh_r[0];
  end
  // high program address page latches five msbs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phi_r <= '0;
    else if (st_r == S_DACK && scl_fall && page_r == PAGE_PHI[2:0])
      phi_r <= sh_r[PHI_BITS-1:0];
  end
  assign mem_page = page_r;
  assign mem_addr = reg_r;
  assign prog_addr = {phi_r, reg_r};
endmodule : i2c_page_slave
`default_nettype wire

// File: i2c_page_master.sv
// i2c master end commanded over apb registers
`timescale 1ns/1ps
`default_nettype none
module i2c_page_master #(
  parameter int DIV = i2c_page_pkg::SCL_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  i2c_link_if.master link
);
  import i2c_page_pkg::*;
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_RUN = 2'b01, M_DONE = 2'b11} mst_e;
  mst_e st_r;  // command state
  logic [6:0] page_r;  // target page
  logic [7:0] reg_r, wdata_r, rdata_r;
  logic rd_r, nack_r;
  logic [15:0] tick_r;  // half period divider
  logic [7:0] op_r;  // micro-step index
  logic sda_r, scl_r;  // line drive levels
  logic acc;
  assign acc = psel && penable;
  assign pready = 1'b1;  // zero wait states
  assign pslverr = 1'b0;
  // register reads
  always_comb begin
    unique case (paddr)
      OFS_CTRL: prdata = {30'h0, rd_r, 1'b0};
      OFS_ADDR: prdata = {16'h0, reg_r, 1'b0, page_r};
      OFS_WDATA: prdata = {24'h0, wdata_r};
      OFS_STATUS: prdata = {16'h0, rdata_r, 6'h0, nack_r, st_r == M_RUN};
      default: prdata = 32'h0;
    endcase
  end
  // register writes; go starts a frame when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_r <= PAGE_TEST;
      reg_r <= 8'h00;
      wdata_r <= 8'h00;
      rd_r <= 1'b0;
    end else if (acc && pwrite && st_r != M_RUN) begin
      if (paddr == OFS_ADDR) {reg_r, page_r} <= {pwdata[15:8], pwdata[6:0]};
      if (paddr == OFS_WDATA) wdata_r <= pwdata[7:0];
      if (paddr == OFS_CTRL) rd_r <= pwdata[1];
    end
  end
  // frame sequencer: each op is one scl half period; master alone clocks
  // ops: 0 start, then 9 bits per byte as 2 halves each, then stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= M_IDLE;
      tick_r <= 16'h0;
      op_r <= 8'h0;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      nack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      unique case (st_r)
        M_IDLE: begin
          if (acc && pwrite && paddr == OFS_CTRL && pwdata[0]) begin
            st_r <= M_RUN;
            op_r <= 8'h0;
            tick_r <= 16'h0;
            nack_r <= 1'b0;
          end
        end
        M_RUN: begin
          if (tick_r == 16'(DIV - 1)) begin
            tick_r <= 16'h0;
            op_r <= op_r + 8'h1;
            step(op_r);
          end else begin
            tick_r <= tick_r + 16'h1;
          end
        end
        M_DONE: st_r <= M_IDLE;
        default: st_r <= M_IDLE;
      endcase
    end
  end
  // one half-period step; data bits move sda only in scl-low halves, the start and stop edges move it with scl high
  task automatic step(input logic [7:0] op);
    logic [7:0] b;
    logic [4:0] k;
    logic [7:0] cur;  // byte of this slot
    b = 8'h00;
    k = 5'h0;
    cur = 8'h00;
    if (op == 8'd0) begin
      sda_r <= 1'b0;  // start: sda falls while scl high
    end else if (op < 8'd37 || (rd_r && op < 8'd91) || (!rd_r && op < 8'd55)) begin
      // bytes: write = addr, reg, data; read = addr, reg, rs, addr2, data
      b = (op - 8'd1) / 8'd18;
      k = 5'((op - 8'd1) % 8'd18);
      if (rd_r && b == 8'd2) begin
        // repeated start in place of write data
        if (k == 5'd0) scl_r <= 1'b0;
        else if (k == 5'd1) sda_r <= 1'b1;
        else if (k == 5'd2) scl_r <= 1'b1;
        else if (k == 5'd3) begin
          sda_r <= 1'b0;
          op_r <= 8'd55;  // jump to second address
        end
      end else if (k[0] == 1'b0) begin
        scl_r <= 1'b0;  // low half: drive next bit
        if (k < 5'd16) begin
          // first address write bit zero, second read bit one
          // read data byte is released so the slave can drive it
          cur = (b == 8'd0) ? {page_r, 1'b0} : (b == 8'd1) ? reg_r :
            (b == 8'd3) ? {page_r, 1'b1} : rd_r ? 8'hff : wdata_r;
          sda_r <= cur[3'd7 - k[3:1]];
        end else begin
          // ack slot released; after read data no ack, a stop follows
          sda_r <= 1'b1;
        end
      end else begin
        scl_r <= 1'b1;  // high half: sample
        if (k == 5'd17 && link.sda && !(rd_r && b == 8'd4)) nack_r <= 1'b1;
        if (k < 5'd16 && rd_r && b == 8'd4) rdata_r <= {rdata_r[6:0], link.sda};
      end
    end else if (scl_r && sda_r) begin
      scl_r <= 1'b0;  // stop: scl low first
    end else if (!scl_r && sda_r) begin
      sda_r <= 1'b0;  // pull sda low while scl low
    end else if (!scl_r && !sda_r) begin
      scl_r <= 1'b1;  // stop: scl up, then sda rises
    end else begin
      sda_r <= 1'b1;
      st_r <= M_DONE;
    end
  endtask : step
  assign link.scl_o = 1'b0;
  assign link.scl_oe = !scl_r;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = !sda_r;
endmodule : i2c_page_master
`default_nettype wire

// File: i2c_page_link_sva.sv
// protocol checker for the i2c link between page master and page slave
`timescale 1ns/1ps
`default_nettype none
module i2c_page_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  import i2c_page_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic scl_q_r, sda_q_r; // wire levels one cycle ago
  logic in_frame_r, sr_r, rd_r; // frame open, repeated start seen, read byte next
  logic [3:0] cnt_r; // scl rises in the current byte, 9 is the ack slot
  logic [1:0] byte_r; // byte index, saturates so it never wraps back
  logic [7:0] sh_r; // last byte seen on sda
  wire logic rise = scl && !scl_q_r;
  wire logic strt = scl && scl_q_r && sda_q_r && !sda;
  wire logic stp = scl && scl_q_r && !sda_q_r && sda;
  wire logic s_low = sda_s_oe && !sda_s_o; // slave pulls sda low
  // the rise cycle still shows the old count, so it is left out
  wire logic ack0 = scl && !rise && cnt_r == 4'h9 && byte_r == 2'h0; // ack of address byte
  wire logic rd_byte = scl && !rise && rd_r && byte_r == 2'h1 && cnt_r != 4'h0;
  // released lines read high, so history starts high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end
  // frame tracking; the ack bit is kept out of the shifter so the byte stays whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame_r <= 1'b0;
      sr_r <= 1'b0;
      rd_r <= 1'b0;
      cnt_r <= 4'h0;
      byte_r <= 2'h0;
      sh_r <= 8'h00;
    end else if (strt) begin
      sr_r <= in_frame_r;
      in_frame_r <= 1'b1;
      rd_r <= 1'b0;
      cnt_r <= 4'h0;
      byte_r <= 2'h0;
    end else if (stp) begin
      in_frame_r <= 1'b0;
    end else if (rise) begin
      cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
      if (cnt_r != 4'h8) sh_r <= {sh_r[6:0], sda};
      if (cnt_r == 4'h8 && byte_r == 2'h0) rd_r <= sh_r[0] && !sda;
      if (cnt_r == 4'h9 && byte_r != 2'h3) byte_r <= byte_r + 2'h1;
    end
  end
  chk_slave_in_frame: assert property (sda_s_oe |-> in_frame_r)
    else $error("slave drives sda outside a frame");
  chk_idle_scl_high: assert property (!in_frame_r |-> scl)
    else $error("scl low outside a frame");
  chk_slave_scl_high: assert property (scl && $past(scl) |-> $stable(s_low))
    else $error("slave changed sda while scl high");
  chk_scl_low_hold: assert property ($fell(scl) |-> !scl [*3])
    else $error("scl low phase too short");
  chk_test_page_ack: assert property (ack0 && sh_r == {PAGE_TEST, 1'b0} |-> s_low)
    else $error("test page address not acknowledged");
  chk_bad_page_nack: assert property (
    ack0 && sr_r && !(sh_r[7:1] inside {[PAGE_TEST:PAGE_ECACHE]}) |-> !s_low)
    else $error("unassigned page acknowledged");
  chk_read_master_quiet: assert property (rd_byte |-> !(sda_m_oe && !sda_m_o))
    else $error("master pulls sda during read data");
  chk_read_no_ack: assert property (rd_byte && cnt_r == 4'h9 |-> sda)
    else $error("read data byte was acknowledged");
endmodule : i2c_page_link_sva
`default_nettype wire

// File: i2c_slave_memory_access_tb.sv
// self-checking bench: apb-driven page master talking to the page slave
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_memory_access_tb;
  import i2c_page_pkg::*;
  localparam logic [6:0] DATA_PAGES [4] = '{PAGE_TEST, PAGE_RAM, PAGE_EFR, PAGE_ECACHE};
  localparam logic [7:0] EE_BANK_REG = 8'h0d; // eeprom access control test register
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic mem_grant = 1'b0; // grant starts clear, as after power-up
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_word; // rd_word holds prdata of the last apb transfer
  logic pready, pslverr, mem_we, mem_re;
  logic [2:0] mem_page;
  logic [7:0] mem_addr, mem_wdata, mem_rdata;
  logic [PADDR_BITS-1:0] prog_addr;
  logic [18:0] exp_q [$]; // expected memory writes {page, addr, data}
  int miscompares = 0;
  int total_checks = 0;
  always #5 pclk = ~pclk;
  // far memory: read data is a fixed mix of page and address, held while addr holds
  assign mem_rdata = mem_addr ^ {5'h00, mem_page} ^ 8'ha5;
  i2c_link_if link_i ();
  // short half period keeps frames a few hundred cycles long
  i2c_page_master #(.DIV(4)) i2c_page_master_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link_i));
  i2c_page_slave i2c_page_slave_i (.pclk(pclk), .presetn(presetn), .link(link_i),
    .mem_grant(mem_grant), .mem_we(mem_we), .mem_re(mem_re), .mem_page(mem_page),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .prog_addr(prog_addr));
  i2c_page_link_sva i2c_page_link_sva_i (.pclk(pclk), .presetn(presetn),
    .scl_o(link_i.scl_o), .scl_oe(link_i.scl_oe), .sda_m_o(link_i.sda_m_o),
    .sda_m_oe(link_i.sda_m_oe), .sda_s_o(link_i.sda_s_o), .sda_s_oe(link_i.sda_s_oe),
    .scl(link_i.scl), .sda(link_i.sda));
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  task automatic bad(string msg);
    miscompares++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : bad
  // compare of plain values
  task automatic cmp_v(logic [31:0] got, logic [31:0] exp, string msg);
    total_checks++;
    if (got !== exp) bad(msg);
  endtask : cmp_v
  // compare of a memory write against the oldest note
  task automatic cmp_w(logic [18:0] got);
    logic [18:0] e;
    total_checks++;
    if (exp_q.size() == 0) begin
      bad("unexpected memory write");
    end else begin
      e = exp_q.pop_front();
      if (got !== e) bad("memory write mismatch");
    end
  endtask : cmp_w
  // one apb transfer; entered just after a rising edge, holds until pready
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad("apb timeout");
      close_out();
    end
    rd_word = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // load address and data, launch, then poll busy under a bound
  task automatic frame(logic rd, logic [6:0] pg, logic [7:0] ra, logic [7:0] d);
    int n;
    apb(1'b1, OFS_ADDR, {16'h0000, ra, 1'b0, pg});
    apb(1'b1, OFS_WDATA, {24'h000000, d});
    apb(1'b1, OFS_CTRL, {30'h0, rd, 1'b1});
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd_word[0] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      bad("frame timeout");
      close_out();
    end
  endtask : frame
  // write frame; a note is queued only where the byte must reach memory
  task automatic wr_page(logic [6:0] pg, logic [7:0] ra, logic [7:0] d, logic hit);
    if (hit) exp_q.push_back({pg[2:0], ra, d});
    frame(1'b0, pg, ra, d);
  endtask : wr_page
  function automatic logic [7:0] exp_rd(logic [6:0] pg, logic [7:0] ra);
    return ra ^ {5'h00, pg[2:0]} ^ 8'ha5;
  endfunction : exp_rd
  // watcher: every write strobe is matched with the oldest note
  always @(posedge pclk) begin
    if (mem_we === 1'b1) cmp_w({mem_page, mem_addr, mem_wdata});
  end
  // main sequence
  initial begin
    logic [7:0] ra, d;
    logic [4:0] hi;
    void'($urandom(88));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp_v({30'h0, link_i.scl, link_i.sda}, 32'h3, "lines not released");
    ra = 8'($urandom);
    d = 8'($urandom);
    wr_page(PAGE_TEST, ra, d, 1'b1);
    wr_page(PAGE_RAM, ra, d, 1'b0);
    // core held, grant set, then interface selected: only the grant reaches the port
    mem_grant <= 1'b1;
    // bank select before any cache read
    wr_page(PAGE_TEST, EE_BANK_REG, {5'h00, 3'($urandom)}, 1'b1);
    // each data page (test, ram, efr, cache): write then read back through the repeated start
    foreach (DATA_PAGES[i]) begin
      ra = 8'($urandom);
      d = 8'($urandom);
      wr_page(DATA_PAGES[i], ra, d, 1'b1);
      frame(1'b1, DATA_PAGES[i], ra, 8'h00);
      cmp_v({rd_word[15:8], rd_word[1:0]}, {exp_rd(DATA_PAGES[i], ra), 2'b00}, "read");
    end
    // reserved code: no write, read refused
    wr_page(PAGE_RSVD, ra, d, 1'b0);
    frame(1'b1, PAGE_RSVD, ra, 8'h00);
    cmp_v({31'h0, rd_word[1]}, 32'h1, "reserved page acked");
    // program memory: high bits first, then low address with the byte
    hi = 5'($urandom);
    ra = 8'($urandom);
    d = 8'($urandom);
    wr_page(PAGE_PHI, 8'($urandom), {3'b000, hi}, 1'b0);
    wr_page(PAGE_PLO, ra, d, 1'b1);
    cmp_v({19'h0, prog_addr}, {19'h0, hi, ra}, "program address");
    cmp_v(exp_q.size(), 32'h0, "memory write missing");
    close_out();
  end
endmodule : i2c_slave_memory_access_tb
`default_nettype wire
